// File: rtl/smbus_dev_end.sv
// Device end of the SMBus link: slave with address pointer and register strobes.
// How it works
// - Fixed variant answers only address 0x2e.
// - First byte is address then direction bit.
// - Strap high gives default address, low hardwired.
// - Hardwired mode: select pin picks 0x2c/0x2d.
// - Strap and select sampled once after reset.
// - Address locked at eighth rise of match.
// - Nine clocks per byte, MSB first, receiver acks.
// - Data moves at SCL low; rise-high means stop.
// - Host ends a write with stop.
// - Host ends a read with no-ack, then stop.
// - Direction fixed until a new start.
// - Writes take one or two bytes; reads one.
// - First write byte loads the pointer.
// - Second write byte goes to pointed register.
// - Pointer-only write leaves data registers alone.
// - Plain read returns the pointed register.
// - Pointer write, repeated start, one-byte read.
// - Repeated start decodes a fresh address byte.
// - Send byte: address and command both acknowledged.
// - Write byte: three bytes, each acknowledged.
// - Quiet bus for 35 ms resets the slave.
// - Timeout disable input stops that reset.
module smbus_dev_end #(
	parameter bit ADDR_SELECTABLE = 1'b1,
	parameter int TIMEOUT_CYC = smbus_pkg::TIMEOUT_CYCLES
) (
	input wire logic clk_sys,
	input wire logic resetn,
	smbus_if.dev bus,
	input wire logic address_select_enable_strap,
	input wire logic address_select,
	input wire logic bus_timeout_disable,
	input wire logic [7:0] reg_rd_data,
	output logic [7:0] reg_index,
	output logic reg_wr_stb,
	output logic [7:0] reg_wr_data,
	output logic [6:0] active_address,
	output logic address_locked
);
	import smbus_pkg::*;

	typedef struct packed {
		logic scl_s1;
		logic scl_s2;
		logic scl_d;
		logic sda_s1;
		logic sda_s2;
		logic sda_d;
		logic en_s1;
		logic en_s2;
		logic sel_s1;
		logic sel_s2;
		logic [1:0] init_cnt;
		logic strap_en;
		logic strap_sel;
		logic locked;
		logic [6:0] slave_addr;
		dev_state_type st;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic [1:0] byte_n;
		logic rd;
		logic match;
		logic [7:0] pointer;
		logic wr_stb;
		logic [7:0] wr_data;
		logic sda_oe_n;
		to_cnt_type to_cnt;
	} dev_regs_type;

	dev_regs_type r_reg;
	dev_regs_type r_next;
	logic scl_rise;
	logic scl_fall;
	logic sda_edge;
	logic bus_start;
	logic bus_stop;
	logic timeout_hit;
	logic [6:0] sel_addr;

	// Edges and conditions seen on the synchronised bus lines.
	assign scl_rise = r_reg.scl_s2 & ~r_reg.scl_d;
	assign scl_fall = ~r_reg.scl_s2 & r_reg.scl_d;
	assign sda_edge = r_reg.sda_s2 ^ r_reg.sda_d;
	assign bus_start = r_reg.scl_s2 & r_reg.scl_d & r_reg.sda_d & ~r_reg.sda_s2;
	assign bus_stop = r_reg.scl_s2 & r_reg.scl_d & ~r_reg.sda_d & r_reg.sda_s2;

	// Quiet-bus timeout, unless software has turned it off.
	assign timeout_hit = ~bus_timeout_disable
		& (r_reg.to_cnt == to_cnt_type'(TIMEOUT_CYC));

	// Address in force: the locked one, else the one chosen by the straps.
	always_comb begin
		if (r_reg.locked) begin
			sel_addr = r_reg.slave_addr;
		end else if (!ADDR_SELECTABLE || r_reg.strap_en) begin
			sel_addr = FIXED_ADDR;
		end else if (r_reg.strap_sel) begin
			sel_addr = SEL_ADDR_HIGH;
		end else begin
			sel_addr = SEL_ADDR_LOW;
		end
	end

	// Next-state logic of the whole slave.
	always_comb begin
		r_next = r_reg;
		r_next.scl_s1 = bus.scl;
		r_next.scl_s2 = r_reg.scl_s1;
		r_next.scl_d = r_reg.scl_s2;
		r_next.sda_s1 = bus.sda;
		r_next.sda_s2 = r_reg.sda_s1;
		r_next.sda_d = r_reg.sda_s2;
		r_next.en_s1 = address_select_enable_strap;
		r_next.en_s2 = r_reg.en_s1;
		r_next.sel_s1 = address_select;
		r_next.sel_s2 = r_reg.sel_s1;
		r_next.wr_stb = 1'b0;

		// The straps are taken once, right after the synchronisers fill.
		if (r_reg.init_cnt != STRAP_DONE) begin
			r_next.init_cnt = r_reg.init_cnt + 2'h1;
			if (r_reg.init_cnt == STRAP_WAIT) begin
				r_next.strap_en = r_reg.en_s2;
				r_next.strap_sel = r_reg.sel_s2;
			end
		end

		// Any bus edge restarts the quiet-bus counter.
		if (r_reg.st == D_IDLE || scl_rise || scl_fall || sda_edge) begin
			r_next.to_cnt = '0;
		end else begin
			r_next.to_cnt = r_reg.to_cnt + to_cnt_type'(1);
		end

		if (bus_start) begin
			// A start, repeated or not, begins a fresh address byte.
			r_next.st = D_RX;
			r_next.cnt = '0;
			r_next.byte_n = BYTE_ADDR;
			r_next.rd = 1'b0;
			r_next.match = 1'b0;
			r_next.sda_oe_n = 1'b1;
		end else if (bus_stop || timeout_hit) begin
			// Stop or timeout releases the bus and parks the slave.
			r_next.st = D_IDLE;
			r_next.sda_oe_n = 1'b1;
		end else begin
			unique case (r_reg.st)
				D_IDLE: begin
					r_next.sda_oe_n = 1'b1;
				end
				D_RX: begin
					// Bits are taken on the rising clock, first bit most significant.
					if (scl_rise) begin
						r_next.sh = {r_reg.sh[6:0], r_reg.sda_s2};
						r_next.cnt = r_reg.cnt + 4'h1;
						if (r_reg.cnt == LAST_DATA_BIT && r_reg.byte_n == BYTE_ADDR) begin
							r_next.rd = r_reg.sda_s2;
							r_next.match = (r_reg.init_cnt == STRAP_DONE)
								&& (r_reg.sh[6:0] == sel_addr);
							if (r_reg.init_cnt == STRAP_DONE && r_reg.sh[6:0] == sel_addr
								&& !r_reg.locked) begin
								r_next.locked = 1'b1;
								r_next.slave_addr = sel_addr;
							end
						end
					end
					// After the eighth bit, acknowledge or drop out.
					if (scl_fall && r_reg.cnt == DATA_BITS) begin
						if ((r_reg.byte_n == BYTE_ADDR && !r_reg.match)
							|| r_reg.byte_n == BYTE_EXTRA) begin
							r_next.st = D_IDLE;
						end else begin
							r_next.sda_oe_n = 1'b0;
							r_next.st = D_ACK;
							if (r_reg.byte_n == BYTE_PTR) begin
								r_next.pointer = r_reg.sh;
							end
							if (r_reg.byte_n == BYTE_DATA) begin
								r_next.wr_stb = 1'b1;
								r_next.wr_data = r_reg.sh;
							end
						end
					end
				end
				D_ACK: begin
					// The acknowledge is held for the whole ninth clock.
					if (scl_fall) begin
						r_next.cnt = '0;
						r_next.byte_n = r_reg.byte_n + 2'h1;
						if (r_reg.rd) begin
							r_next.st = D_TX;
							r_next.sh = reg_rd_data;
							r_next.sda_oe_n = reg_rd_data[7];
						end else begin
							r_next.st = D_RX;
							r_next.sda_oe_n = 1'b1;
						end
					end
				end
				D_TX: begin
					// One byte goes out, changing only while the clock is low.
					if (scl_rise) begin
						r_next.cnt = r_reg.cnt + 4'h1;
					end
					if (scl_fall) begin
						if (r_reg.cnt == DATA_BITS) begin
							r_next.sda_oe_n = 1'b1;
							r_next.st = D_IDLE;
						end else begin
							r_next.sh = {r_reg.sh[6:0], 1'b0};
							r_next.sda_oe_n = r_reg.sh[6];
						end
					end
				end
			endcase
		end
	end

	// State register; the pointer keeps its value across transactions.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			r_reg <= '0;
			r_reg.scl_s1 <= 1'b1;
			r_reg.scl_s2 <= 1'b1;
			r_reg.scl_d <= 1'b1;
			r_reg.sda_s1 <= 1'b1;
			r_reg.sda_s2 <= 1'b1;
			r_reg.sda_d <= 1'b1;
			r_reg.st <= D_IDLE;
			r_reg.pointer <= PTR_RESET;
			r_reg.sda_oe_n <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	// Outputs come straight from the state register.
	assign reg_index = r_reg.pointer;
	assign reg_wr_stb = r_reg.wr_stb;
	assign reg_wr_data = r_reg.wr_data;
	assign active_address = r_reg.slave_addr;
	assign address_locked = r_reg.locked;
	assign bus.dev_sda_oe_n = r_reg.sda_oe_n;
	assign bus.dev_sda_o = 1'b0; // Open drain: only ever pulls low.
endmodule

// File: inc/smbus_pkg.sv
// Shared constants and types for both ends of the SMBus register link.
package smbus_pkg;
	// Slave addresses.
	localparam logic [6:0] FIXED_ADDR = 7'h2e;
	localparam logic [6:0] SEL_ADDR_LOW = 7'h2c;
	localparam logic [6:0] SEL_ADDR_HIGH = 7'h2d;
	// Value of the address pointer after reset.
	localparam logic [7:0] PTR_RESET = 8'h00;
	// Clock rates and times.
	localparam int CLK_HZ = 100_000_000;
	localparam int TIMEOUT_MS = 35;
	localparam int TIMEOUT_CYCLES = TIMEOUT_MS * (CLK_HZ / 1000);
	localparam int SCL_HZ = 100_000;
	localparam int QTR_CYCLES = CLK_HZ / (4 * SCL_HZ);
	// Bit and byte positions inside a transfer.
	localparam logic [3:0] DATA_BITS = 4'h8;
	localparam logic [3:0] LAST_DATA_BIT = 4'h7;
	localparam logic [1:0] BYTE_ADDR = 2'h0;
	localparam logic [1:0] BYTE_PTR = 2'h1;
	localparam logic [1:0] BYTE_DATA = 2'h2;
	localparam logic [1:0] BYTE_EXTRA = 2'h3;
	// Strap capture waits for the two synchroniser stages.
	localparam logic [1:0] STRAP_WAIT = 2'h2;
	localparam logic [1:0] STRAP_DONE = 2'h3;
	typedef logic [21:0] to_cnt_type;
	typedef logic [15:0] qtr_cnt_type;
	typedef enum logic [3:0] {
		D_IDLE = 4'b0001,
		D_RX = 4'b0010,
		D_ACK = 4'b0100,
		D_TX = 4'b1000
	} dev_state_type;
	typedef enum logic [3:0] {
		H_IDLE = 4'b0001,
		H_START = 4'b0010,
		H_BIT = 4'b0100,
		H_STOP = 4'b1000
	} host_state_type;
	typedef enum logic [1:0] {
		CMD_SEND = 2'h0,
		CMD_WRITE = 2'h1,
		CMD_RECEIVE = 2'h2,
		CMD_READ_BYTE = 2'h3
	} host_cmd_type;
endpackage

// File: inc/smbus_if.sv
// Open-drain SMBus wires shared by the host end and the device end.
interface smbus_if;
	logic scl;
	logic sda;
	logic host_scl_o;
	logic host_scl_oe_n;
	logic host_sda_o;
	logic host_sda_oe_n;
	logic dev_sda_o;
	logic dev_sda_oe_n;
	// Pull-ups win unless an enabled driver pulls the wire.
	assign scl = host_scl_oe_n ? 1'b1 : host_scl_o;
	assign sda = (host_sda_oe_n ? 1'b1 : host_sda_o) & (dev_sda_oe_n ? 1'b1 : dev_sda_o);
	modport dev(input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
	modport host(
		input scl,
		input sda,
		output host_scl_o,
		output host_scl_oe_n,
		output host_sda_o,
		output host_sda_oe_n
	);
endinterface

// File: rtl/smbus_host_end.sv
// Host end of the SMBus link: runs send, write, receive and read-byte transfers.
module smbus_host_end #(
	parameter int QTR_CYC = smbus_pkg::QTR_CYCLES
) (
	input wire logic clk_sys,
	input wire logic resetn,
	smbus_if.host bus,
	input wire logic cmd_valid,
	input wire smbus_pkg::host_cmd_type cmd_kind,
	input wire logic [6:0] cmd_address,
	input wire logic [7:0] cmd_pointer,
	input wire logic [7:0] cmd_data,
	output logic cmd_ready,
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	output logic rsp_nack
);
	import smbus_pkg::*;

	typedef struct packed {
		logic sda_s1;
		logic sda_s2;
		qtr_cnt_type qcnt;
		host_state_type st;
		logic [1:0] q;
		logic [3:0] bit_n;
		logic [1:0] byte_n;
		logic rx;
		logic rd;
		logic second;
		host_cmd_type kind;
		logic [6:0] addr;
		logic [7:0] ptr;
		logic [7:0] data;
		logic [7:0] sh;
		logic nack;
		logic scl_oe_n;
		logic sda_oe_n;
		logic ready;
		logic rsp_valid;
		logic [7:0] rsp_data;
		logic rsp_nack;
	} host_regs_type;

	host_regs_type r_reg;
	host_regs_type r_next;
	logic qtick;
	logic dir;

	// Quarter-period enable of the SCL divider and the direction to send.
	assign qtick = r_reg.qcnt == qtr_cnt_type'(QTR_CYC - 1);
	assign dir = (r_reg.kind == CMD_RECEIVE) | r_reg.second;

	// Next-state logic; each bus step takes one quarter of an SCL period.
	always_comb begin
		r_next = r_reg;
		r_next.sda_s1 = bus.sda;
		r_next.sda_s2 = r_reg.sda_s1;
		r_next.rsp_valid = 1'b0;
		if (r_reg.st == H_IDLE || qtick) begin
			r_next.qcnt = '0;
		end else begin
			r_next.qcnt = r_reg.qcnt + qtr_cnt_type'(1);
		end
		if (qtick) begin
			r_next.q = r_reg.q + 2'h1;
		end
		unique case (r_reg.st)
			H_IDLE: begin
				r_next.ready = 1'b1;
				if (cmd_valid && r_reg.ready) begin
					r_next.ready = 1'b0;
					r_next.kind = cmd_kind;
					r_next.addr = cmd_address;
					r_next.ptr = cmd_pointer;
					r_next.data = cmd_data;
					r_next.second = 1'b0;
					r_next.nack = 1'b0;
					r_next.q = 2'h0;
					r_next.st = H_START;
				end
			end
			H_START: begin
				// Release both lines, then pull SDA low while SCL is high.
				if (qtick) begin
					unique case (r_reg.q)
						2'h0: r_next.sda_oe_n = 1'b1;
						2'h1: r_next.scl_oe_n = 1'b1;
						2'h2: r_next.sda_oe_n = 1'b0;
						2'h3: begin
							r_next.scl_oe_n = 1'b0;
							r_next.st = H_BIT;
							r_next.bit_n = '0;
							r_next.byte_n = BYTE_ADDR;
							r_next.rx = 1'b0;
							r_next.rd = dir;
							r_next.sh = {r_reg.addr, dir};
						end
					endcase
				end
			end
			H_BIT: begin
				if (qtick) begin
					unique case (r_reg.q)
						2'h0: begin
							// Data changes only while SCL is low; a read is left released.
							if (r_reg.bit_n < DATA_BITS && !r_reg.rx) begin
								r_next.sda_oe_n = r_reg.sh[7];
							end else begin
								r_next.sda_oe_n = 1'b1;
							end
						end
						2'h1: r_next.scl_oe_n = 1'b1;
						2'h2: begin
							if (r_reg.bit_n < DATA_BITS) begin
								r_next.sh = {r_reg.sh[6:0], r_reg.sda_s2};
							end else if (!r_reg.rx) begin
								r_next.nack = r_reg.sda_s2;
							end
						end
						2'h3: begin
							r_next.scl_oe_n = 1'b0;
							r_next.bit_n = r_reg.bit_n + 4'h1;
							if (r_reg.bit_n == DATA_BITS) begin
								// Byte finished: pick the next step of the protocol.
								r_next.bit_n = '0;
								if (r_reg.rx) begin
									r_next.rsp_data = r_reg.sh;
									r_next.st = H_STOP;
								end else if (r_reg.nack) begin
									r_next.st = H_STOP;
								end else if (r_reg.byte_n == BYTE_ADDR && r_reg.rd) begin
									r_next.rx = 1'b1;
								end else if (r_reg.byte_n == BYTE_ADDR) begin
									r_next.sh = r_reg.ptr;
									r_next.byte_n = BYTE_PTR;
								end else if (r_reg.byte_n == BYTE_PTR
									&& r_reg.kind == CMD_WRITE) begin
									r_next.sh = r_reg.data;
									r_next.byte_n = BYTE_DATA;
								end else if (r_reg.byte_n == BYTE_PTR
									&& r_reg.kind == CMD_READ_BYTE) begin
									r_next.second = 1'b1;
									r_next.st = H_START;
								end else begin
									r_next.st = H_STOP;
								end
							end
						end
					endcase
				end
			end
			H_STOP: begin
				// Pull SDA low, raise SCL, then let SDA rise while SCL is high.
				if (qtick) begin
					unique case (r_reg.q)
						2'h0: r_next.sda_oe_n = 1'b0;
						2'h1: r_next.scl_oe_n = 1'b1;
						2'h2: r_next.sda_oe_n = 1'b1;
						2'h3: begin
							r_next.st = H_IDLE;
							r_next.ready = 1'b1;
							r_next.rsp_valid = 1'b1;
							r_next.rsp_nack = r_reg.nack;
						end
					endcase
				end
			end
		endcase
	end

	// State register.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			r_reg <= '0;
			r_reg.sda_s1 <= 1'b1;
			r_reg.sda_s2 <= 1'b1;
			r_reg.st <= H_IDLE;
			r_reg.kind <= CMD_SEND;
			r_reg.scl_oe_n <= 1'b1;
			r_reg.sda_oe_n <= 1'b1;
			r_reg.ready <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	// Outputs come straight from the state register; drivers only pull low.
	assign cmd_ready = r_reg.ready;
	assign rsp_valid = r_reg.rsp_valid;
	assign rsp_data = r_reg.rsp_data;
	assign rsp_nack = r_reg.rsp_nack;
	assign bus.host_scl_oe_n = r_reg.scl_oe_n;
	assign bus.host_sda_oe_n = r_reg.sda_oe_n;
	assign bus.host_scl_o = 1'b0;
	assign bus.host_sda_o = 1'b0;
endmodule

// File: dv/smbus_link_chk.sv
// Protocol checker for the open-drain wires between the host end and the device end.
module smbus_link_chk (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic scl,
	input wire logic sda,
	input wire logic host_sda_oe_n,
	input wire logic dev_sda_oe_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic scl_q;
	logic rd_reg;
	logic [3:0] rise_mod;
	logic [1:0] byte_no;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);
	// Tracks the pulse within a byte, the byte count and the direction bit since a start.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			scl_q <= 1'b1;
			rd_reg <= 1'b0;
			rise_mod <= 4'h0;
			byte_no <= 2'h0;
		end else begin
			scl_q <= scl;
			if (scl && $fell(sda)) begin
				rise_mod <= 4'h0;
				byte_no <= 2'h0;
				rd_reg <= 1'b0;
			end else if (scl && !scl_q) begin
				rise_mod <= (rise_mod == 4'h8) ? 4'h0 : rise_mod + 4'h1;
				if (rise_mod == 4'h8 && byte_no != 2'h3) begin
					byte_no <= byte_no + 2'h1;
				end
				if (rise_mod == 4'h7 && byte_no == 2'h0) begin
					rd_reg <= sda;
				end
			end
		end
	end
	sequence s_start;
		scl && $fell(sda);
	endsequence
	sequence s_stop;
		scl && $rose(sda);
	endsequence
	property p_dev_edge_scl_low;
		$changed(dev_sda_oe_n) |-> !scl && !$past(scl);
	endproperty
	property p_stop_tenth;
		s_stop |-> rise_mod == 4'h1;
	endproperty
	property p_ack_slot_write;
		scl && scl_q && !dev_sda_oe_n && !rd_reg |-> rise_mod == 4'h0 && byte_no != 2'h0;
	endproperty
	property p_read_one_byte;
		scl && scl_q && !dev_sda_oe_n && rd_reg |-> byte_no == 2'h1;
	endproperty
	property p_release_after_ack;
		$fell(scl) && rise_mod == 4'h0 && !dev_sda_oe_n && !rd_reg |-> ##[1:8] dev_sda_oe_n;
	endproperty
	property p_scl_high_time;
		$rose(scl) |-> scl [*8];
	endproperty
	// The host may still hold its last data bit low in the low phase before the ack.
	property p_no_collision;
		scl && scl_q && !dev_sda_oe_n |-> host_sda_oe_n;
	endproperty
	property p_start_then_low;
		s_start |-> ##[1:40] !scl;
	endproperty
	a_dev_edge_scl_low: assert property (p_dev_edge_scl_low)
		else $error("device moved sda while scl was high");
	a_stop_tenth: assert property (p_stop_tenth)
		else $error("stop not on the tenth clock");
	a_ack_slot_write: assert property (p_ack_slot_write)
		else $error("device pulled sda outside an ack slot");
	a_read_one_byte: assert property (p_read_one_byte)
		else $error("device drove sda outside its one read byte");
	a_release_after_ack: assert property (p_release_after_ack)
		else $error("device held ack past the ninth clock");
	a_scl_high_time: assert property (p_scl_high_time)
		else $error("scl high period too short");
	a_no_collision: assert property (p_no_collision)
		else $error("both ends pulled sda");
	a_start_then_low: assert property (p_start_then_low)
		else $error("no clock after start");
endmodule

// File: dv/smbus_slave_register_port_test.sv
// Self-checking bench: host end drives the device end across the shared SMBus wires.
module smbus_slave_register_port_test;
	timeunit 1ns;
	timeprecision 1ps;
	import smbus_pkg::*;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic strap = 1'b0;
	logic sel = 1'b0;
	logic to_dis = 1'b0;
	logic cmd_valid = 1'b0;
	host_cmd_type cmd_kind = CMD_SEND;
	logic [6:0] cmd_address = 7'h00;
	logic [7:0] cmd_pointer = 8'h00;
	logic [7:0] cmd_data = 8'h00;
	logic cmd_ready, rsp_valid, rsp_nack, reg_wr_stb, address_locked;
	logic [7:0] rsp_data, reg_rd_data, reg_index, reg_wr_data;
	logic [6:0] active_address;
	logic [7:0] regs [256];
	int err_total = 0;
	int checks_done = 0;
	int cycles = 0;
	smbus_if link();
	smbus_host_end #(.QTR_CYC(25)) smbus_host_end_inst (.clk_sys(clk_sys), .resetn(resetn),
		.bus(link.host), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_address(cmd_address),
		.cmd_pointer(cmd_pointer), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_nack(rsp_nack));
	smbus_dev_end #(.ADDR_SELECTABLE(1'b1), .TIMEOUT_CYC(20000)) smbus_dev_end_inst (
		.clk_sys(clk_sys), .resetn(resetn), .bus(link.dev), .address_select_enable_strap(strap),
		.address_select(sel), .bus_timeout_disable(to_dis), .reg_rd_data(reg_rd_data),
		.reg_index(reg_index), .reg_wr_stb(reg_wr_stb), .reg_wr_data(reg_wr_data),
		.active_address(active_address), .address_locked(address_locked));
	smbus_link_chk smbus_link_chk_inst (.clk_sys(clk_sys), .resetn(resetn), .scl(link.scl),
		.sda(link.sda), .host_sda_oe_n(link.host_sda_oe_n), .dev_sda_oe_n(link.dev_sda_oe_n));
	// Register file behind the device end; reads are combinational from the pointer.
	assign reg_rd_data = regs[reg_index];
	always @(posedge clk_sys) begin
		if (reg_wr_stb === 1'b1) begin
			regs[reg_index] <= reg_wr_data;
		end
	end
	// Free-running clock and a watchdog that cuts a hang short.
	always begin
		#5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			err_total++;
			end_of_test();
		end
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		checks_done++;
		if (seen !== want) begin
			err_total++;
			$display("[ERR] time=%0t seen=%h expected=%h", $time, seen, want);
		end
	endtask
	task automatic test_done(input string name);
		$display("test %s done: checks %0d, mismatches %0d", name, checks_done, err_total);
	endtask
	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Straps are set while reset is low and kept steady past the capture edges.
	task automatic do_reset(input logic strap_lvl, input logic sel_lvl);
		@(posedge clk_sys);
		resetn <= 1'b0;
		strap <= strap_lvl;
		sel <= sel_lvl;
		repeat (2) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (6) @(posedge clk_sys);
	endtask
	// One host command, valid for a single clock, then waits for the end-of-transfer pulse.
	task automatic run_cmd(input host_cmd_type kind, input logic [6:0] addr,
		input logic [7:0] ptr, input logic [7:0] data);
		int n;
		@(posedge clk_sys);
		cmd_valid <= 1'b1;
		cmd_kind <= kind;
		cmd_address <= addr;
		cmd_pointer <= ptr;
		cmd_data <= data;
		@(posedge clk_sys);
		cmd_valid <= 1'b0;
		@(negedge clk_sys);
		check({7'h00, cmd_ready}, 8'h00);
		for (n = 0; n < 9000 && rsp_valid !== 1'b1; n++) begin
			@(negedge clk_sys);
		end
		check({7'h00, rsp_valid}, 8'h01);
		check({7'h00, cmd_ready}, 8'h01);
	endtask
	// Main sequence: hardwired address first, then the default address after a new reset.
	initial begin
		for (int i = 0; i < 256; i++) begin
			regs[i] = 8'(i) ^ 8'h3c;
		end
		do_reset(1'b0, 1'b1);
		check(reg_index, PTR_RESET);
		run_cmd(CMD_WRITE, SEL_ADDR_LOW, 8'h05, 8'hff);
		check({7'h00, rsp_nack}, 8'h01);
		check(regs[5], 8'h05 ^ 8'h3c);
		check({7'h00, address_locked}, 8'h00);
		test_done("wrong address");
		run_cmd(CMD_WRITE, SEL_ADDR_HIGH, 8'h05, 8'ha5);
		check({7'h00, rsp_nack}, 8'h00);
		check(regs[5], 8'ha5);
		check({1'b0, active_address}, {1'b0, SEL_ADDR_HIGH});
		check({7'h00, address_locked}, 8'h01);
		test_done("write byte");
		@(posedge clk_sys);
		sel <= 1'b0;
		run_cmd(CMD_SEND, SEL_ADDR_HIGH, 8'h07, 8'h00);
		check({7'h00, rsp_nack}, 8'h00);
		check(reg_index, 8'h07);
		check(regs[7], 8'h07 ^ 8'h3c);
		test_done("send byte");
		repeat (2) begin
			run_cmd(CMD_RECEIVE, SEL_ADDR_HIGH, 8'h00, 8'h00);
			check({7'h00, rsp_nack}, 8'h00);
			check(rsp_data, 8'h07 ^ 8'h3c);
		end
		test_done("receive byte");
		run_cmd(CMD_READ_BYTE, SEL_ADDR_HIGH, 8'h05, 8'h00);
		check(rsp_data, 8'ha5);
		check(reg_index, 8'h05);
		run_cmd(CMD_SEND, SEL_ADDR_LOW, 8'h01, 8'h00);
		check({7'h00, rsp_nack}, 8'h01);
		check(reg_index, 8'h05);
		test_done("read byte and locked address");
		do_reset(1'b1, 1'b0);
		check(reg_index, PTR_RESET);
		run_cmd(CMD_WRITE, FIXED_ADDR, 8'h03, 8'h5a);
		check({7'h00, rsp_nack}, 8'h00);
		check(regs[3], 8'h5a);
		check({1'b0, active_address}, {1'b0, FIXED_ADDR});
		run_cmd(CMD_RECEIVE, SEL_ADDR_LOW, 8'h00, 8'h00);
		check({7'h00, rsp_nack}, 8'h01);
		test_done("default address");
		end_of_test();
	end
endmodule
